/* File: verilog/bertpg_top.v */
// Bit error rate tester: receive checker, transmit generator, error insertion
// Assumes bit strobes and counter update come from logic on clk
// Function
// RULE1: Out-of-sync shown whenever not in Sync
// RULE2: Out-of-sync cleared on reaching Sync
// RULE3: Sync change latches; interrupt only if enabled
// RULE4: Mismatch latches error, counts bit and error
// RULE5: Match counts bit only
// RULE6: No counting while out of sync
// RULE7: Bit error interrupt only if enabled
// RULE8: 32-bit shift register, feedback into bit 1
// RULE9: PRBS taps n,y; repetitive uses bit n
// RULE10: Length and tap fields give n, y
// RULE11: Serial output equals feedback
// RULE12: QUASI_RANDOM_MODE taps 17,20; 14 zeros force one
// RULE13: All-zero bits 1-31 force feedback one; code does so only when not repetitive
// RULE14: Pattern load presets seed
// RULE15: Invert bit complements transmitted pattern
// RULE16: Single or rate errors, 3-bit rate field
// RULE17: Single error needs enable; register or pin
// RULE18: Pin rising edges give one error
// RULE19: Load on rising bit, only when enabled
// RULE20: Six errors in 64 bits resynchronise
// RULE21: Update copies counts to holds, clears counters
// RULE22: Rate zero off, else one per 10^n
// RULE23: Counters saturate; error flips one bit
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "bertpg_map.vh"

module bertpg_top #(
   parameter CW = 32
) (
   input wire clk,
   input wire resetn,
   input wire [3:0] addr,
   input wire [15:0] wdata,
   input wire wr,
   input wire rd,
   output reg [15:0] rdata,
   input wire rx_data,
   input wire rx_strobe,
   input wire tx_strobe,
   output reg tx_data,
   input wire manual_error_pin,
   input wire perf_update,
   output reg irq
);

   localparam ST_LOAD = 3'b001;
   localparam ST_CHECK = 3'b010;
   localparam ST_SYNC = 3'b100;

   // One error per 10^n bits, terminal count
   function [23:0] rate_last;
      input [2:0] n;
      begin
         case (n)
            3'h1: rate_last = 24'h000009;
            3'h2: rate_last = 24'h000063;
            3'h3: rate_last = 24'h0003e7;
            3'h4: rate_last = 24'h00270f;
            3'h5: rate_last = 24'h01869f;
            3'h6: rate_last = 24'h0f423f;
            3'h7: rate_last = 24'h98967f;
            default: rate_last = 24'h000000;
         endcase
      end
   endfunction

   // Saturating increment
   function [CW-1:0] sat_inc;
      input [CW-1:0] v;
      begin
         sat_inc = (&v) ? v : v + {{(CW-1){1'b0}}, 1'b1};
      end
   endfunction

   reg [15:0] ctrl_reg;
   reg [15:0] pcfg_reg;
   reg [31:0] seed_reg;
   reg [4:0] eins_reg;
   reg [1:0] latch_reg;
   reg [1:0] irqen_reg;
   reg [CW-1:0] bcnt_reg;
   reg [CW-1:0] ecnt_reg;
   reg [CW-1:0] bhold_reg;
   reg [CW-1:0] ehold_reg;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg oos_reg;
   reg [5:0] chk_cnt_reg;
   reg [5:0] win_cnt_reg;
   reg [2:0] win_err_reg;
   reg [23:0] rate_cnt_reg;
   reg single_pend_reg;
   reg pin_s1_reg;
   reg pin_s2_reg;
   reg pin_s3_reg;
   reg [15:0] rd_mux;

   wire enable = ctrl_reg[`BERTPG_CTRL_ENABLE];
   wire ctrl_wr = wr && addr == `BERTPG_ADDR_CTRL;
   wire [15:0] ctrl_rise = ctrl_wr ? (wdata & ~ctrl_reg) : 16'h0000;
   wire tx_load = ctrl_rise[`BERTPG_CTRL_TX_LOAD] && enable; // see RULE19
   wire rx_load = ctrl_rise[`BERTPG_CTRL_RX_LOAD] && enable; // see RULE19
   wire man_resync = ctrl_rise[`BERTPG_CTRL_MAN_RESYNC];
   wire cnt_update = ctrl_rise[`BERTPG_CTRL_CNT_UPD] || perf_update;
   wire rx_inv = ctrl_reg[`BERTPG_CTRL_RX_INV];
   wire tx_inv = ctrl_reg[`BERTPG_CTRL_TX_INV];
   wire [4:0] tap_m1 = pcfg_reg[`BERTPG_PCFG_TAP_LSB +: 5];
   wire [4:0] len_m1 = pcfg_reg[`BERTPG_PCFG_LEN_LSB +: 5];
   wire rep = pcfg_reg[`BERTPG_PCFG_REP];
   wire quasi_random_mode = pcfg_reg[`BERTPG_PCFG_QUASI_RANDOM_MODE];
   wire [2:0] rate_sel = eins_reg[`BERTPG_EINS_RATE_LSB +: 3];
   wire single_en = eins_reg[`BERTPG_EINS_SINGLE_EN];

   wire rx_bit = rx_data ^ rx_inv;
   wire rx_pat;
   wire tx_pat;
   wire rx_shift = enable && rx_strobe;
   wire tx_shift = enable && tx_strobe;
   wire mismatch = rx_shift && (rx_bit != rx_pat);
   wire in_sync = state_reg == ST_SYNC;
   wire count_bit = rx_shift && in_sync; // see RULE6
   wire count_err = mismatch && in_sync;

   // ------------------------------------------------------------
   // Pattern generators
   // ------------------------------------------------------------
   bertpg_gen #(.W(32)) u_tx_gen (
      .clk(clk),
      .resetn(resetn),
      .load(tx_load),
      .seed(seed_reg),
      .shift(tx_shift),
      .take_din(1'b0),
      .din(1'b0),
      .len_m1(len_m1),
      .tap_m1(tap_m1),
      .rep(rep),
      .quasi_random_mode(quasi_random_mode),
      .pat_out(tx_pat)
   );

   bertpg_gen #(.W(32)) u_rx_gen (
      .clk(clk),
      .resetn(resetn),
      .load(rx_load),
      .seed(seed_reg),
      .shift(rx_shift),
      .take_din(state_reg == ST_LOAD),
      .din(rx_bit),
      .len_m1(len_m1),
      .tap_m1(tap_m1),
      .rep(rep),
      .quasi_random_mode(quasi_random_mode),
      .pat_out(rx_pat)
   );

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (!resetn) begin
         ctrl_reg <= `BERTPG_CTRL_RST;
         pcfg_reg <= `BERTPG_PCFG_RST;
         seed_reg <= `BERTPG_SEED_RST;
         eins_reg <= `BERTPG_EINS_RST;
         irqen_reg <= 2'b00;
      end else if (wr) begin
         case (addr)
            `BERTPG_ADDR_CTRL: ctrl_reg <= wdata;
            `BERTPG_ADDR_PCFG: pcfg_reg <= wdata;
            `BERTPG_ADDR_SEED_LO: seed_reg[15:0] <= wdata;
            `BERTPG_ADDR_SEED_HI: seed_reg[31:16] <= wdata;
            `BERTPG_ADDR_EINS: eins_reg <= {1'b0, wdata[3:0]}; // see RULE16
            `BERTPG_ADDR_IRQEN: irqen_reg <= wdata[1:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Receive synchronisation
   // ------------------------------------------------------------
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_LOAD: begin
            if (rx_shift && chk_cnt_reg == `BERTPG_CHECK_BITS) begin
               state_next = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (mismatch) begin
               state_next = ST_LOAD;
            end else if (rx_shift && chk_cnt_reg == `BERTPG_CHECK_BITS) begin
               state_next = ST_SYNC;
            end
         end
         ST_SYNC: begin
            if (mismatch && win_err_reg >= `BERTPG_RESYNC_ERRS - 3'h1
                && !ctrl_reg[`BERTPG_CTRL_RESYNC_DIS]) begin
               state_next = ST_LOAD; // see RULE20
            end
         end
         default: state_next = ST_LOAD;
      endcase
      if (man_resync || rx_load || !enable) begin
         state_next = ST_LOAD;
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         state_reg <= ST_LOAD;
         oos_reg <= 1'b1;
         chk_cnt_reg <= 6'h00;
         win_cnt_reg <= 6'h00;
         win_err_reg <= 3'h0;
      end else begin
         state_reg <= state_next;
         oos_reg <= state_next != ST_SYNC; // see RULE1 RULE2
         if (state_next != state_reg || rx_load || man_resync || !enable) begin
            chk_cnt_reg <= 6'h00; // see RULE19
         end else if (rx_shift) begin
            chk_cnt_reg <= chk_cnt_reg + 6'h01;
         end
         if (state_next != ST_SYNC || (rx_shift && win_cnt_reg == `BERTPG_WINDOW_LAST)) begin
            win_cnt_reg <= 6'h00;
            win_err_reg <= 3'h0;
         end else if (rx_shift) begin
            win_cnt_reg <= win_cnt_reg + 6'h01;
            if (mismatch && win_err_reg != 3'h7) begin
               win_err_reg <= win_err_reg + 3'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Counters, holds and latched flags
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (!resetn) begin
         bcnt_reg <= {CW{1'b0}};
         ecnt_reg <= {CW{1'b0}};
         bhold_reg <= {CW{1'b0}};
         ehold_reg <= {CW{1'b0}};
      end else if (cnt_update) begin
         bhold_reg <= bcnt_reg; // see RULE21
         ehold_reg <= ecnt_reg;
         bcnt_reg <= {{(CW-1){1'b0}}, count_bit};
         ecnt_reg <= {{(CW-1){1'b0}}, count_err};
      end else begin
         if (count_bit) begin
            bcnt_reg <= sat_inc(bcnt_reg); // see RULE4 RULE5 RULE23
         end
         if (count_err) begin
            ecnt_reg <= sat_inc(ecnt_reg); // see RULE4 RULE23
         end
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         latch_reg <= 2'b00;
         irq <= 1'b0;
      end else begin
         if (wr && addr == `BERTPG_ADDR_LATCH) begin
            latch_reg <= (latch_reg & ~wdata[1:0])
                         | {count_err, oos_reg != (state_next != ST_SYNC)};
         end else begin
            latch_reg <= latch_reg | {count_err, oos_reg != (state_next != ST_SYNC)}; // see RULE3
         end
         irq <= |(latch_reg & irqen_reg); // see RULE3 RULE7
      end
   end

   // ------------------------------------------------------------
   // Transmit path and error insertion
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (!resetn) begin
         pin_s1_reg <= 1'b0;
         pin_s2_reg <= 1'b0;
         pin_s3_reg <= 1'b0;
         single_pend_reg <= 1'b0;
         rate_cnt_reg <= 24'h000000;
         tx_data <= 1'b0;
      end else begin
         pin_s1_reg <= manual_error_pin;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         if (single_en && ((pin_s2_reg && !pin_s3_reg) // see RULE17 RULE18
             || (wr && addr == `BERTPG_ADDR_EINS && wdata[`BERTPG_EINS_SINGLE_GO]))) begin
            single_pend_reg <= 1'b1;
         end else if (tx_shift) begin
            single_pend_reg <= 1'b0;
         end
         if (rate_sel == 3'h0 || !enable) begin
            rate_cnt_reg <= 24'h000000; // see RULE22
         end else if (tx_shift) begin
            rate_cnt_reg <= (rate_cnt_reg >= rate_last(rate_sel)) ? 24'h000000
                            : rate_cnt_reg + 24'h000001;
         end
         if (tx_shift) begin
            tx_data <= tx_pat ^ tx_inv // see RULE15
                       ^ (single_pend_reg || (rate_sel != 3'h0
                          && rate_cnt_reg >= rate_last(rate_sel))); // see RULE16 RULE23
         end
      end
   end

   // ------------------------------------------------------------
   // Register reads
   // ------------------------------------------------------------
   always @* begin
      case (addr)
         `BERTPG_ADDR_CTRL: rd_mux = ctrl_reg;
         `BERTPG_ADDR_PCFG: rd_mux = pcfg_reg;
         `BERTPG_ADDR_SEED_LO: rd_mux = seed_reg[15:0];
         `BERTPG_ADDR_SEED_HI: rd_mux = seed_reg[31:16];
         `BERTPG_ADDR_EINS: rd_mux = {11'h000, single_pend_reg, eins_reg[3:0]};
         `BERTPG_ADDR_STAT: rd_mux = {14'h0000, ecnt_reg != {CW{1'b0}}, oos_reg};
         `BERTPG_ADDR_LATCH: rd_mux = {14'h0000, latch_reg};
         `BERTPG_ADDR_IRQEN: rd_mux = {14'h0000, irqen_reg};
         `BERTPG_ADDR_BCNT_LO: rd_mux = bhold_reg[15:0];
         `BERTPG_ADDR_BCNT_HI: rd_mux = bhold_reg[31:16];
         `BERTPG_ADDR_ECNT_LO: rd_mux = ehold_reg[15:0];
         `BERTPG_ADDR_ECNT_HI: rd_mux = ehold_reg[31:16];
         default: rd_mux = 16'h0000;
      endcase
   end

   always @(posedge clk) begin
      if (!resetn) begin
         rdata <= 16'h0000;
      end else if (rd) begin
         rdata <= rd_mux;
      end else begin
         rdata <= 16'h0000;
      end
   end

endmodule

`default_nettype wire

/* File: verilog/bertpg_map.vh */
// Register map, field positions and reset values of the pattern tester
// Assumes a 16-bit register port with word indexes as addresses
`ifndef BERTPG_MAP_VH
`define BERTPG_MAP_VH

// ------------------------------------------------------------
// Register indexes
// ------------------------------------------------------------
`define BERTPG_ADDR_CTRL 4'h0
`define BERTPG_ADDR_PCFG 4'h1
`define BERTPG_ADDR_SEED_LO 4'h2
`define BERTPG_ADDR_SEED_HI 4'h3
`define BERTPG_ADDR_EINS 4'h4
`define BERTPG_ADDR_STAT 4'h5
`define BERTPG_ADDR_LATCH 4'h6
`define BERTPG_ADDR_IRQEN 4'h7
`define BERTPG_ADDR_BCNT_LO 4'h8
`define BERTPG_ADDR_BCNT_HI 4'h9
`define BERTPG_ADDR_ECNT_LO 4'ha
`define BERTPG_ADDR_ECNT_HI 4'hb

// ------------------------------------------------------------
// Control register bits
// ------------------------------------------------------------
`define BERTPG_CTRL_ENABLE 0
`define BERTPG_CTRL_TX_LOAD 1
`define BERTPG_CTRL_RX_LOAD 2
`define BERTPG_CTRL_CNT_UPD 3
`define BERTPG_CTRL_RESYNC_DIS 4
`define BERTPG_CTRL_TX_INV 5
`define BERTPG_CTRL_RX_INV 6
`define BERTPG_CTRL_MAN_RESYNC 7

// ------------------------------------------------------------
// Pattern configuration fields
// ------------------------------------------------------------
`define BERTPG_PCFG_TAP_LSB 0
`define BERTPG_PCFG_LEN_LSB 8
`define BERTPG_PCFG_REP 13
`define BERTPG_PCFG_QUASI_RANDOM_MODE 14

// ------------------------------------------------------------
// Error insertion and status fields
// ------------------------------------------------------------
`define BERTPG_EINS_RATE_LSB 0
`define BERTPG_EINS_SINGLE_EN 3
`define BERTPG_EINS_SINGLE_GO 4
`define BERTPG_STAT_OOS 0
`define BERTPG_STAT_ECNZ 1
`define BERTPG_LATCH_SYNC 0
`define BERTPG_LATCH_BERR 1

// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define BERTPG_CTRL_RST 16'h0000
`define BERTPG_PCFG_RST 16'h0000
`define BERTPG_SEED_RST 32'hffffffff
`define BERTPG_EINS_RST 5'h00
`define BERTPG_CHECK_BITS 6'h1f
`define BERTPG_WINDOW_LAST 6'h3f
`define BERTPG_RESYNC_ERRS 3'h6

`endif

/* File: verilog/bertpg_gen.v */
// 32-bit pattern shift register with PRBS, QUASI_RANDOM_MODE and repetitive feedback
// Assumes shift and load are one-cycle strobes in the caller's clock domain
`timescale 1ns/1ps
`default_nettype none

module bertpg_gen #(
   parameter W = 32
) (
   input wire clk,
   input wire resetn,
   input wire load,
   input wire [W-1:0] seed,
   input wire shift,
   input wire take_din,
   input wire din,
   input wire [4:0] len_m1,
   input wire [4:0] tap_m1,
   input wire rep,
   input wire quasi_random_mode,
   output wire pat_out
);

   reg [W-1:0] sr_reg;
   reg fb;
   reg pat;

   // ------------------------------------------------------------
   // Feedback and serial output
   // ------------------------------------------------------------
   always @* begin
      if (quasi_random_mode) begin
         fb = sr_reg[16] ^ sr_reg[19]; // see RULE12
      end else if (rep) begin
         fb = sr_reg[len_m1]; // see RULE9
      end else begin
         fb = sr_reg[len_m1] ^ sr_reg[tap_m1]; // see RULE9 RULE10
      end
      if (!rep && sr_reg[30:0] == 31'h00000000) begin
         fb = 1'b1; // see RULE13
      end
      pat = fb; // see RULE11
      if (quasi_random_mode && sr_reg[13:0] == 14'h0000) begin
         pat = 1'b1; // see RULE12
      end
   end

   assign pat_out = pat;

   // ------------------------------------------------------------
   // Shift register, bit 1 toward bit 32
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (!resetn) begin
         sr_reg <= {W{1'b1}};
      end else if (load) begin
         sr_reg <= seed; // see RULE14
      end else if (shift) begin
         sr_reg <= {sr_reg[W-2:0], take_din ? din : fb}; // see RULE8
      end
   end

endmodule

`default_nettype wire

/* File: tb/bertpg_line.sv */
// Line partner: sends bit strobes and loops transmit data back to receive
// Assumes one go pulse per bit from the bench, all on clk
`timescale 1ns/1ps
`default_nettype none
module bertpg_line (
   input wire logic clk,
   input wire logic go,
   input wire logic tx_data,
   output logic tx_strobe,
   output logic rx_strobe,
   output logic rx_data
);
   logic [2:0] st_reg = 3'h0;
   logic junk_reg = 1'b0;
   always @(posedge clk) begin
      st_reg <= {st_reg[1:0], go};
      junk_reg <= ~junk_reg;
   end
   assign tx_strobe = st_reg[0];
   assign rx_strobe = st_reg[2];
   // Idle line toggles so stale data never passes for a bit
   assign rx_data = rx_strobe ? tx_data : junk_reg;
endmodule
`default_nettype wire

/* File: tb/bertpg_top_monitor.sv */
// Port checker for the pattern tester
// Assumes one clock, resetn synchronous active low
`timescale 1ns/1ps
`default_nettype none
module bertpg_top_monitor #(
   parameter CW = 32
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic tx_strobe,
   input wire logic tx_data,
   input wire logic irq
);
   // ------------------------------------------------------------
   // Interrupt enable shadow
   // ------------------------------------------------------------
   logic [1:0] irqen_reg;
   always @(posedge clk) begin
      if (!resetn) begin
         irqen_reg <= 2'h0;
      end else if (wr && addr == 4'h7) begin
         irqen_reg <= wdata[1:0];
      end
   end
   default clocking mon_cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence masked_two;
      irqen_reg == 2'h0 ##1 irqen_reg == 2'h0;
   endsequence
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   rd_idle_a:
      assert property (!rd |=> rdata == 16'h0) else $error("Read data outside slot");
   unmapped_zero_a:
      assert property (rd && addr >= 4'hc |=> rdata == 16'h0) else $error("Unmapped read");
   irqen_read_a:
      assert property (rd && addr == 4'h7 |=> rdata[1:0] == irqen_reg) else $error("Enable read");
   irq_masked_a:
      assert property (masked_two |-> !irq) else $error("Interrupt while masked");
   irq_cause_a:
      assert property ($rose(irq) |-> $past(irqen_reg) != 2'h0) else $error("Interrupt cause");
   tx_hold_a:
      assert property (!tx_strobe |=> $stable(tx_data)) else $error("Transmit bit moved");
   rst_tx_a:
      assert property (disable iff (1'b0) !resetn |=> !tx_data && rdata == 16'h0)
         else $error("Outputs not quiet in reset");
   rst_irq_a:
      assert property (disable iff (1'b0) !resetn |=> !irq) else $error("Interrupt in reset");
endmodule
bind bertpg_top bertpg_top_monitor #(.CW(CW)) bertpg_top_monitor_inst (.clk(clk),
   .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .tx_strobe(tx_strobe), .tx_data(tx_data), .irq(irq));
`default_nettype wire

/* File: tb/bertpg_top_tb_top.sv */
// Bench for the pattern tester: register tasks, line partner, pattern checks
// Assumes the register map header and a 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "bertpg_map.vh"
module bertpg_top_tb_top;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic go = 1'b0;
   logic pin = 1'b0;
   logic upd = 1'b0;
   logic [15:0] rdata;
   logic tx_data, irq, tx_strobe, rx_strobe, rx_data, fb, exp_bit;
   logic [31:0] s;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   bertpg_top bertpg_top_inst (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .rx_data(rx_data), .rx_strobe(rx_strobe),
      .tx_strobe(tx_strobe), .tx_data(tx_data), .manual_error_pin(pin),
      .perf_update(upd), .irq(irq));
   bertpg_line bertpg_line_inst (.clk(clk), .go(go), .tx_data(tx_data),
      .tx_strobe(tx_strobe), .rx_strobe(rx_strobe), .rx_data(rx_data));
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         conclude();
      end
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic conclude();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      cmp(rdata & m, e);
   endtask
   task automatic bits(input int k);
      repeat (k) begin
         @(posedge clk);
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic update();
      @(posedge clk);
      upd <= 1'b1;
      @(posedge clk);
      upd <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic pin_pulse();
      @(posedge clk);
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      pin <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic irq_chk(input logic e);
      repeat (2) @(posedge clk);
      #1;
      cmp({15'h0, irq}, {15'h0, e});
   endtask
   task automatic gen_chk(input logic [4:0] len, input logic [4:0] tap, input logic rep,
                          input logic q, input logic [31:0] seed, input logic inv);
      wr_reg(`BERTPG_ADDR_PCFG, {1'b0, q, rep, len, 3'h0, tap});
      wr_reg(`BERTPG_ADDR_SEED_LO, seed[15:0]);
      wr_reg(`BERTPG_ADDR_SEED_HI, seed[31:16]);
      wr_reg(`BERTPG_ADDR_CTRL, {10'h0, inv, 5'h01});
      wr_reg(`BERTPG_ADDR_CTRL, {10'h0, inv, 5'h03});
      s = seed;
      repeat (40) begin
         fb = q ? s[16] ^ s[19] : rep ? s[len] : s[len] ^ s[tap];
         if (!rep && s[30:0] == 31'h0) fb = 1'b1;
         exp_bit = (q && s[13:0] == 14'h0) ? 1'b1 : fb;
         s = {s[30:0], fb};
         bits(1);
         cmp({15'h0, tx_data}, {15'h0, exp_bit ^ inv});
      end
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd_chk(`BERTPG_ADDR_CTRL, 16'hffff, 16'h0);
      rd_chk(`BERTPG_ADDR_SEED_HI, 16'hffff, 16'hffff);
      rd_chk(`BERTPG_ADDR_STAT, 16'h1, 16'h1);
      rd_chk(4'hc, 16'hffff, 16'h0);
      bits(4);
      cmp({15'h0, tx_data}, 16'h0);
      gen_chk(5'h03, 5'h00, 1'b1, 1'b0, 32'hfffffff1, 1'b0);
      gen_chk(5'h08, 5'h04, 1'b0, 1'b0, 32'h0, 1'b1);
      gen_chk(5'h13, 5'h02, 1'b0, 1'b1, 32'hffffc000, 1'b0);
      gen_chk(5'h08, 5'h04, 1'b0, 1'b0, 32'hffffffff, 1'b0);
      wr_reg(`BERTPG_ADDR_LATCH, 16'h3);
      wr_reg(`BERTPG_ADDR_CTRL, 16'h0001);
      wr_reg(`BERTPG_ADDR_CTRL, 16'h0007);
      bits(63);
      rd_chk(`BERTPG_ADDR_STAT, 16'h1, 16'h1);
      bits(1);
      rd_chk(`BERTPG_ADDR_STAT, 16'h1, 16'h0);
      rd_chk(`BERTPG_ADDR_LATCH, 16'h3, 16'h1);
      wr_reg(`BERTPG_ADDR_IRQEN, 16'h1);
      irq_chk(1'b1);
      wr_reg(`BERTPG_ADDR_IRQEN, 16'h0);
      irq_chk(1'b0);
      wr_reg(`BERTPG_ADDR_LATCH, 16'h3);
      update();
      bits(20);
      wr_reg(`BERTPG_ADDR_CTRL, 16'h000f);
      rd_chk(`BERTPG_ADDR_BCNT_LO, 16'hffff, 16'd20);
      rd_chk(`BERTPG_ADDR_ECNT_LO, 16'hffff, 16'h0);
      wr_reg(`BERTPG_ADDR_IRQEN, 16'h2);
      wr_reg(`BERTPG_ADDR_EINS, 16'h0008);
      wr_reg(`BERTPG_ADDR_EINS, 16'h0018);
      bits(10);
      update();
      rd_chk(`BERTPG_ADDR_ECNT_LO, 16'hffff, 16'h1);
      rd_chk(`BERTPG_ADDR_BCNT_LO, 16'hffff, 16'd10);
      rd_chk(`BERTPG_ADDR_LATCH, 16'h2, 16'h2);
      irq_chk(1'b1);
      wr_reg(`BERTPG_ADDR_IRQEN, 16'h0);
      pin_pulse();
      pin_pulse();
      bits(10);
      update();
      rd_chk(`BERTPG_ADDR_ECNT_LO, 16'hffff, 16'h1);
      wr_reg(`BERTPG_ADDR_EINS, 16'h0000);
      pin_pulse();
      bits(64);
      update();
      rd_chk(`BERTPG_ADDR_ECNT_LO, 16'hffff, 16'h0);
      wr_reg(`BERTPG_ADDR_EINS, 16'h0001);
      bits(40);
      update();
      rd_chk(`BERTPG_ADDR_ECNT_LO, 16'hffff, 16'h4);
      wr_reg(`BERTPG_ADDR_EINS, 16'h0000);
      bits(20);
      update();
      rd_chk(`BERTPG_ADDR_ECNT_LO, 16'hffff, 16'h0);
      wr_reg(`BERTPG_ADDR_LATCH, 16'h3);
      wr_reg(`BERTPG_ADDR_CTRL, 16'h0051);
      bits(16);
      rd_chk(`BERTPG_ADDR_STAT, 16'h1, 16'h0);
      update();
      rd_chk(`BERTPG_ADDR_ECNT_LO, 16'hffff, 16'h10);
      wr_reg(`BERTPG_ADDR_CTRL, 16'h0041);
      bits(64);
      rd_chk(`BERTPG_ADDR_STAT, 16'h1, 16'h1);
      rd_chk(`BERTPG_ADDR_LATCH, 16'h1, 16'h1);
      update();
      bits(20);
      update();
      rd_chk(`BERTPG_ADDR_BCNT_LO, 16'hffff, 16'h0);
      wr_reg(`BERTPG_ADDR_CTRL, 16'h0001);
      bits(128);
      rd_chk(`BERTPG_ADDR_STAT, 16'h1, 16'h0);
      wr_reg(`BERTPG_ADDR_CTRL, 16'h0081);
      rd_chk(`BERTPG_ADDR_STAT, 16'h1, 16'h1);
      conclude();
   end
endmodule
`default_nettype wire
